// file: csc_pkg.sv
// constants and types shared by the core system-control register bank
package csc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // register addresses
  localparam logic [7:0] ADDR_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_SP = 8'h02;
  localparam logic [7:0] ADDR_CLKMD = 8'h03;
  localparam logic [7:0] ADDR_INTEN = 8'h04;
  localparam logic [7:0] ADDR_INTRQ = 8'h05;
  localparam logic [7:0] ADDR_INTCLR = 8'h07;
  localparam logic [7:0] ADDR_EDGESEL = 8'h08;
  localparam logic [7:0] ADDR_PAIE = 8'h09;

  // arithmetic status flag positions
  localparam int unsigned FLAG_OV = 3;
  localparam int unsigned FLAG_AC = 2;
  localparam int unsigned FLAG_C = 1;
  localparam int unsigned FLAG_Z = 0;

  // clock-mode field positions
  localparam int unsigned CLKMD_SEL_MSB = 7;
  localparam int unsigned CLKMD_SEL_LSB = 5;
  localparam int unsigned CLKMD_FAST_EN = 4;
  localparam int unsigned CLKMD_TYPE = 3;
  localparam int unsigned CLKMD_SLOW_EN = 2;
  localparam int unsigned CLKMD_WDT_EN = 1;
  localparam int unsigned CLKMD_RSTPIN = 0;

  // interrupt source positions, shared by enable, request and clear
  localparam int unsigned IRQ_THIRD_TMR = 7;
  localparam int unsigned IRQ_SECOND_TMR = 6;
  localparam int unsigned IRQ_PWM = 5;
  localparam int unsigned IRQ_CMP = 4;
  localparam int unsigned IRQ_T16 = 2;
  localparam int unsigned IRQ_PB = 1;
  localparam int unsigned IRQ_PA = 0;
  localparam logic [7:0] IRQ_IMPL_MASK = 8'hf7;

  // values after reset and fixed read values
  localparam logic [3:0] FLAGS_RST = 4'h4;
  localparam logic [3:0] FLAGS_RSVD_READ = 4'hf;
  localparam logic [7:0] SP_RST = 8'h00;
  localparam logic [7:0] CLKMD_RST = 8'hf6;
  localparam logic [7:0] INTEN_RST = 8'h00;
  localparam logic [7:0] INTRQ_RST = 8'h00;
  localparam logic [3:0] EDGESEL_RST = 4'h0;
  localparam logic PAIE_RST = 1'b1;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // edge selection codes for the edge-sensing pins
  localparam logic [1:0] EDGE_BOTH = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;

  typedef enum logic [1:0] {CSC_OP_ADD, CSC_OP_SUB, CSC_OP_LOGIC, CSC_OP_SHIFT} csc_alu_op_type;

  typedef enum logic [1:0] {CSC_SRC_FAST, CSC_SRC_SLOW, CSC_SRC_XTAL, CSC_SRC_NONE} csc_clk_src_type;

  // system clock choice: source, divide as a power of two, reserved code
  typedef struct packed {
    csc_clk_src_type src;
    logic [2:0] div_log2;
    logic rsvd;
  } csc_clk_sel_type;

  localparam csc_clk_sel_type CLK_TYPE0 [8] = '{
    '{CSC_SRC_FAST, 3'h2, 1'b0}, '{CSC_SRC_FAST, 3'h1, 1'b0},
    '{CSC_SRC_NONE, 3'h0, 1'b1}, '{CSC_SRC_XTAL, 3'h2, 1'b0},
    '{CSC_SRC_XTAL, 3'h1, 1'b0}, '{CSC_SRC_XTAL, 3'h0, 1'b0},
    '{CSC_SRC_SLOW, 3'h2, 1'b0}, '{CSC_SRC_SLOW, 3'h0, 1'b0}};

  localparam csc_clk_sel_type CLK_TYPE1 [8] = '{
    '{CSC_SRC_FAST, 3'h4, 1'b0}, '{CSC_SRC_FAST, 3'h3, 1'b0},
    '{CSC_SRC_SLOW, 3'h4, 1'b0}, '{CSC_SRC_FAST, 3'h5, 1'b0},
    '{CSC_SRC_FAST, 3'h6, 1'b0}, '{CSC_SRC_XTAL, 3'h3, 1'b0},
    '{CSC_SRC_NONE, 3'h0, 1'b1}, '{CSC_SRC_NONE, 3'h0, 1'b1}};

endpackage : csc_pkg

// file: csc_core_regs.sv
// core system-control register bank: flags, stack pointer, clock mode, interrupts
//
// Operation
// - status register bits 7..4 always read back as ones.
// - bit 3 is set on signed overflow; software may read and write it.
// - bit 2 is nibble carry on add, nibble borrow on subtract.
// - bit 1 is carry on add, borrow on subtract; shifts through carry update it.
// - bit 0 is set for a zero result, cleared for non-zero.
// - stack pointer is read/write; software keeps its bit 0 at zero.
// - clock-mode bit 3 picks one of two selector tables; resets to 0.
// - bits 7..5 choose the system clock per table; reserved codes; reset 111.
// - clock-mode bit 4 enables the fast RC oscillator; resets to 1.
// - bit 2 enables slow RC oscillator, reset 1; clearing it stops watchdog.
// - bit 1 enables the watchdog timer; resets to 1.
// - bit 0 selects shared pin as IO (0) or reset input (1); reset 0.
// - enable register has one read/write bit per source; bit 3 reserved.
// - each source sets its request bit at the same position; bit 3 reserved.
// - sixteen-bit timer event sets request bit 2; enable bit 2 gates only the interrupt.
// - pin edge select: 00 both, 01 rising, 10 falling, 11 reserved.
// - port-A input disabled means no request and no wake from that pin.
`timescale 1ns/100ps

module csc_core_regs (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic alu_valid_i,
  input wire csc_pkg::csc_alu_op_type alu_op_i,
  input wire logic [7:0] alu_a_i,
  input wire logic [7:0] alu_b_i,
  input wire logic alu_cin_i,
  input wire logic [7:0] alu_logic_res_i,
  input wire logic alu_shift_c_i,
  output logic [3:0] arith_flags_o,
  output logic [7:0] stack_pointer_o,
  input wire logic third_timer_evt_i,
  input wire logic second_timer_evt_i,
  input wire logic pwm_generator_zero_evt_i,
  input wire logic comparator_evt_i,
  input wire logic sixteen_bit_timer_evt_i,
  input wire logic port_a_edge_pin_i,
  input wire logic port_b_edge_pin_i,
  output csc_pkg::csc_clk_src_type sys_clk_src_o,
  output logic [2:0] sys_clk_div_log2_o,
  output logic sys_clk_sel_rsvd_o,
  output logic fast_internal_rc_osc_en_o,
  output logic slow_internal_rc_osc_en_o,
  output logic watchdog_en_o,
  output logic external_reset_input_sel_o,
  output logic port_a_wake_o,
  output logic irq_o
);

  typedef struct packed {
    logic ov;
    logic ac;
    logic c;
    logic z;
    logic [7:0] sp;
    logic [7:0] clkmd;
    logic [7:0] inten;
    logic [7:0] intrq;
    logic [3:0] edge_sel;
    logic pa_in_en;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [1:0] pin_prev;
    logic [7:0] rd_data;
    csc_pkg::csc_clk_sel_type clk_sel;
    logic wdt_run;
    logic irq;
    logic pa_wake;
  } csc_state_type;

  localparam csc_state_type STATE_RST = '{
    ov: csc_pkg::FLAGS_RST[csc_pkg::FLAG_OV],
    ac: csc_pkg::FLAGS_RST[csc_pkg::FLAG_AC],
    c: csc_pkg::FLAGS_RST[csc_pkg::FLAG_C],
    z: csc_pkg::FLAGS_RST[csc_pkg::FLAG_Z],
    sp: csc_pkg::SP_RST,
    clkmd: csc_pkg::CLKMD_RST,
    inten: csc_pkg::INTEN_RST,
    intrq: csc_pkg::INTRQ_RST,
    edge_sel: csc_pkg::EDGESEL_RST,
    pa_in_en: csc_pkg::PAIE_RST,
    pin_s1: 2'h0,
    pin_s2: 2'h0,
    pin_prev: 2'h0,
    rd_data: csc_pkg::RD_UNMAPPED,
    clk_sel: csc_pkg::CLK_TYPE0[3'h7],
    wdt_run: csc_pkg::CLKMD_RST[csc_pkg::CLKMD_WDT_EN] & csc_pkg::CLKMD_RST[csc_pkg::CLKMD_SLOW_EN],
    irq: 1'b0,
    pa_wake: 1'b0
  };

  csc_state_type q;
  csc_state_type d;

  logic [8:0] add_sum;
  logic [4:0] add_lo;
  logic [8:0] sub_diff;
  logic [4:0] sub_lo;
  logic add_ov;
  logic sub_ov;
  logic pa_hit;
  logic pb_hit;
  logic [7:0] hw_set;

  // true when the selected edge shows between two synchronised samples
  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
    logic hit;
    hit = 1'b0;
    case (sel)
      csc_pkg::EDGE_BOTH: hit = prev ^ cur;
      csc_pkg::EDGE_RISE: hit = ~prev & cur;
      csc_pkg::EDGE_FALL: hit = prev & ~cur;
      default: hit = 1'b0; // reserved code raises nothing
    endcase
    return hit;
  endfunction : edge_hit

  function automatic csc_pkg::csc_clk_sel_type clk_decode(input logic [2:0] code,
                                                          input logic table_one);
    csc_pkg::csc_clk_sel_type sel;
    sel = table_one ? csc_pkg::CLK_TYPE1[code] : csc_pkg::CLK_TYPE0[code];
    return sel;
  endfunction : clk_decode

  // arithmetic with carry or borrow in; bit 8 and bit 4 are the carries out
  assign add_sum = {1'b0, alu_a_i} + {1'b0, alu_b_i} + {8'h00, alu_cin_i};
  assign add_lo = {1'b0, alu_a_i[3:0]} + {1'b0, alu_b_i[3:0]} + {4'h0, alu_cin_i};
  assign sub_diff = {1'b0, alu_a_i} - {1'b0, alu_b_i} - {8'h00, alu_cin_i};
  assign sub_lo = {1'b0, alu_a_i[3:0]} - {1'b0, alu_b_i[3:0]} - {4'h0, alu_cin_i};
  assign add_ov = (alu_a_i[7] == alu_b_i[7]) && (add_sum[7] != alu_a_i[7]);
  assign sub_ov = (alu_a_i[7] != alu_b_i[7]) && (sub_diff[7] != alu_a_i[7]);

  always_comb begin
    d = q;
    d.rd_data = csc_pkg::RD_UNMAPPED;

    // pins cross from outside: two flops before the edge detector looks
    d.pin_s1 = {port_b_edge_pin_i, port_a_edge_pin_i};
    d.pin_s2 = q.pin_s1;
    d.pin_prev = q.pin_s2;
    pa_hit = q.pa_in_en & edge_hit(q.edge_sel[1:0], q.pin_prev[0], q.pin_s2[0]);
    pb_hit = edge_hit(q.edge_sel[3:2], q.pin_prev[1], q.pin_s2[1]);
    d.pa_wake = q.pa_in_en & (q.pin_prev[0] ^ q.pin_s2[0]);

    hw_set = 8'h00;
    hw_set[csc_pkg::IRQ_THIRD_TMR] = third_timer_evt_i;
    hw_set[csc_pkg::IRQ_SECOND_TMR] = second_timer_evt_i;
    hw_set[csc_pkg::IRQ_PWM] = pwm_generator_zero_evt_i;
    hw_set[csc_pkg::IRQ_CMP] = comparator_evt_i;
    hw_set[csc_pkg::IRQ_T16] = sixteen_bit_timer_evt_i;
    hw_set[csc_pkg::IRQ_PB] = pb_hit;
    hw_set[csc_pkg::IRQ_PA] = pa_hit;

    if (reg_wr_i) begin
      case (reg_addr_i)
        csc_pkg::ADDR_FLAGS: begin
          d.ov = reg_wdata_i[csc_pkg::FLAG_OV];
          d.ac = reg_wdata_i[csc_pkg::FLAG_AC];
          d.c = reg_wdata_i[csc_pkg::FLAG_C];
          d.z = reg_wdata_i[csc_pkg::FLAG_Z];
        end
        // bit 0 is stored as written; keeping it even is software's job
        csc_pkg::ADDR_SP: d.sp = reg_wdata_i;
        csc_pkg::ADDR_CLKMD: d.clkmd = reg_wdata_i;
        csc_pkg::ADDR_INTEN: d.inten = reg_wdata_i & csc_pkg::IRQ_IMPL_MASK;
        csc_pkg::ADDR_INTRQ: d.intrq = reg_wdata_i;
        csc_pkg::ADDR_INTCLR: d.intrq = q.intrq & ~reg_wdata_i;
        csc_pkg::ADDR_EDGESEL: d.edge_sel = reg_wdata_i[3:0];
        csc_pkg::ADDR_PAIE: d.pa_in_en = reg_wdata_i[0];
        default: d.intrq = q.intrq;
      endcase
    end

    // hardware sets win over a software clear in the same cycle
    d.intrq = (d.intrq | hw_set) & csc_pkg::IRQ_IMPL_MASK;

    // the core's flag update lands after a same-cycle software write
    if (alu_valid_i) begin
      unique case (alu_op_i)
        csc_pkg::CSC_OP_ADD: begin
          d.ov = add_ov;
          d.ac = add_lo[4];
          d.c = add_sum[8];
          d.z = (add_sum[7:0] == 8'h00);
        end
        csc_pkg::CSC_OP_SUB: begin
          d.ov = sub_ov;
          d.ac = sub_lo[4];
          d.c = sub_diff[8];
          d.z = (sub_diff[7:0] == 8'h00);
        end
        csc_pkg::CSC_OP_LOGIC: d.z = (alu_logic_res_i == 8'h00);
        csc_pkg::CSC_OP_SHIFT: d.c = alu_shift_c_i;
      endcase
    end

    if (reg_rd_i) begin
      case (reg_addr_i)
        csc_pkg::ADDR_FLAGS: d.rd_data = {csc_pkg::FLAGS_RSVD_READ, q.ov, q.ac, q.c, q.z};
        csc_pkg::ADDR_SP: d.rd_data = q.sp;
        csc_pkg::ADDR_CLKMD: d.rd_data = q.clkmd;
        csc_pkg::ADDR_INTEN: d.rd_data = q.inten;
        csc_pkg::ADDR_INTRQ: d.rd_data = q.intrq;
        csc_pkg::ADDR_EDGESEL: d.rd_data = {4'h0, q.edge_sel};
        csc_pkg::ADDR_PAIE: d.rd_data = {7'h00, q.pa_in_en};
        default: d.rd_data = csc_pkg::RD_UNMAPPED;
      endcase
    end

    // decoded outputs follow the next register value so they line up with it
    d.clk_sel = clk_decode(d.clkmd[csc_pkg::CLKMD_SEL_MSB:csc_pkg::CLKMD_SEL_LSB],
                           d.clkmd[csc_pkg::CLKMD_TYPE]);
    d.wdt_run = d.clkmd[csc_pkg::CLKMD_WDT_EN] & d.clkmd[csc_pkg::CLKMD_SLOW_EN];
    d.irq = |(d.intrq & d.inten);
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o = q.rd_data;
  assign arith_flags_o = {q.ov, q.ac, q.c, q.z};
  assign stack_pointer_o = q.sp;
  assign sys_clk_src_o = q.clk_sel.src;
  assign sys_clk_div_log2_o = q.clk_sel.div_log2;
  assign sys_clk_sel_rsvd_o = q.clk_sel.rsvd;
  assign fast_internal_rc_osc_en_o = q.clkmd[csc_pkg::CLKMD_FAST_EN];
  assign slow_internal_rc_osc_en_o = q.clkmd[csc_pkg::CLKMD_SLOW_EN];
  assign watchdog_en_o = q.wdt_run;
  assign external_reset_input_sel_o = q.clkmd[csc_pkg::CLKMD_RSTPIN];
  assign port_a_wake_o = q.pa_wake;
  assign irq_o = q.irq;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  property p_flags_rsvd_ones;
    reg_rd_i && reg_addr_i == csc_pkg::ADDR_FLAGS |=> reg_rdata_o[7:4] == 4'hf;
  endproperty
  a_flags_rsvd_ones: assert property (p_flags_rsvd_ones)
    else $error("status reserved bits did not read as ones");

  property p_signed_overflow;
    alu_valid_i && alu_op_i == csc_pkg::CSC_OP_ADD && alu_a_i == 8'h7f && alu_b_i == 8'h01
      |=> arith_flags_o[3] && !arith_flags_o[0];
  endproperty
  a_signed_overflow: assert property (p_signed_overflow)
    else $error("signed overflow flag missed on 7f plus 01");

  property p_half_carry;
    alu_valid_i && alu_op_i == csc_pkg::CSC_OP_SUB
      |=> arith_flags_o[2] == ({1'b0, $past(alu_a_i[3:0])}
                               < {1'b0, $past(alu_b_i[3:0])} + {4'h0, $past(alu_cin_i)});
  endproperty
  a_half_carry: assert property (p_half_carry)
    else $error("half carry does not match the nibble borrow");

  property p_carry_add;
    alu_valid_i && alu_op_i == csc_pkg::CSC_OP_ADD
      |=> arith_flags_o[1] == ({1'b0, $past(alu_a_i)} + {1'b0, $past(alu_b_i)} > 9'h0ff - {8'h00, $past(alu_cin_i)});
  endproperty
  a_carry_add: assert property (p_carry_add)
    else $error("carry flag does not match the addition carry");

  property p_zero_logic;
    alu_valid_i && alu_op_i == csc_pkg::CSC_OP_LOGIC
      |=> arith_flags_o[0] == ($past(alu_logic_res_i) == 8'h00);
  endproperty
  a_zero_logic: assert property (p_zero_logic)
    else $error("zero flag wrong after a logic result");

  property p_slow_off_stops_wdt;
    !slow_internal_rc_osc_en_o |-> !watchdog_en_o;
  endproperty
  a_slow_off_stops_wdt: assert property (p_slow_off_stops_wdt)
    else $error("watchdog runs while the slow oscillator is off");

  property p_request_sticky;
    irq_o && !(reg_wr_i && (reg_addr_i == csc_pkg::ADDR_INTRQ || reg_addr_i == csc_pkg::ADDR_INTCLR))
      && !(reg_wr_i && reg_addr_i == csc_pkg::ADDR_INTEN) |=> irq_o;
  endproperty
  a_request_sticky: assert property (p_request_sticky)
    else $error("interrupt dropped without a software write");

  property p_sixteen_bit_timer_sets;
    sixteen_bit_timer_evt_i ##1 (reg_rd_i && reg_addr_i == csc_pkg::ADDR_INTRQ)
      |=> reg_rdata_o[2];
  endproperty
  a_sixteen_bit_timer_sets: assert property (p_sixteen_bit_timer_sets)
    else $error("timer request not visible the cycle after its event");

  property p_pa_disabled_quiet;
    !q.pa_in_en && !q.intrq[csc_pkg::IRQ_PA]
      && !(reg_wr_i && reg_addr_i == csc_pkg::ADDR_INTRQ) |=> !q.intrq[csc_pkg::IRQ_PA] && !port_a_wake_o;
  endproperty
  a_pa_disabled_quiet: assert property (p_pa_disabled_quiet)
    else $error("disabled port A pin raised a request or wake");

  property p_irq_needs_enable;
    irq_o == (|(q.intrq & q.inten));
  endproperty
  a_irq_needs_enable: assert property (p_irq_needs_enable)
    else $error("interrupt raised with no enabled request");

  property p_clk_reset_table;
    $rose(arst_n_i) |-> sys_clk_src_o == csc_pkg::CSC_SRC_SLOW && sys_clk_div_log2_o == 3'h0;
  endproperty
  a_clk_reset_table: assert property (p_clk_reset_table)
    else $error("clock selector not at its reset choice");

  property p_sp_write;
    reg_wr_i && reg_addr_i == csc_pkg::ADDR_SP |=> stack_pointer_o == $past(reg_wdata_i);
  endproperty
  a_sp_write: assert property (p_sp_write)
    else $error("stack pointer did not take the written value");

  property p_inten_rsvd;
    reg_rd_i && reg_addr_i == csc_pkg::ADDR_INTEN |=> !reg_rdata_o[3];
  endproperty
  a_inten_rsvd: assert property (p_inten_rsvd)
    else $error("reserved enable bit read back as one");

  property p_intrq_rsvd;
    reg_rd_i && reg_addr_i == csc_pkg::ADDR_INTRQ |=> !reg_rdata_o[3];
  endproperty
  a_intrq_rsvd: assert property (p_intrq_rsvd)
    else $error("reserved request bit read back as one");

  property p_fast_en;
    reg_wr_i && reg_addr_i == csc_pkg::ADDR_CLKMD
      |=> fast_internal_rc_osc_en_o == $past(reg_wdata_i[csc_pkg::CLKMD_FAST_EN]);
  endproperty
  a_fast_en: assert property (p_fast_en)
    else $error("fast oscillator enable does not follow its bit");

  property p_rstpin_sel;
    reg_wr_i && reg_addr_i == csc_pkg::ADDR_CLKMD
      |=> external_reset_input_sel_o == $past(reg_wdata_i[csc_pkg::CLKMD_RSTPIN]);
  endproperty
  a_rstpin_sel: assert property (p_rstpin_sel)
    else $error("shared pin function does not follow its bit");

  property p_wdt_en;
    reg_wr_i && reg_addr_i == csc_pkg::ADDR_CLKMD
      |=> watchdog_en_o == ($past(reg_wdata_i[1]) && $past(reg_wdata_i[2]));
  endproperty
  a_wdt_en: assert property (p_wdt_en)
    else $error("watchdog enable wrong after a clock-mode write");

  property p_carry_sub;
    alu_valid_i && alu_op_i == csc_pkg::CSC_OP_SUB
      |=> arith_flags_o[1] == ({1'b0, $past(alu_a_i)}
                               < {1'b0, $past(alu_b_i)} + {8'h00, $past(alu_cin_i)});
  endproperty
  a_carry_sub: assert property (p_carry_sub)
    else $error("carry flag does not match the subtraction borrow");

  property p_zero_add;
    alu_valid_i && alu_op_i == csc_pkg::CSC_OP_ADD
      |=> arith_flags_o[0] == (($past(alu_a_i) + $past(alu_b_i) + {7'h00, $past(alu_cin_i)}) == 8'h00);
  endproperty
  a_zero_add: assert property (p_zero_add)
    else $error("zero flag wrong after an addition");

endmodule : csc_core_regs

// file: csc_periph_model.sv
// behavioural model of the peripheral event sources and edge-sensing pins
`timescale 1ns/100ps
module csc_periph_model (
  input wire logic clk_i,
  output logic [7:0] evt_o,
  output logic pin_a_o,
  output logic pin_b_o
);
  initial begin
    evt_o = 8'h00;
    pin_a_o = 1'b0;
    pin_b_o = 1'b0;
  end

  // one-cycle event pulse, bit positions as in the request register
  task automatic pulse(input logic [7:0] mask);
    evt_o <= mask;
    @(posedge clk_i);
    evt_o <= 8'h00;
  endtask : pulse

  // pins are asynchronous; the wait covers two sync flops, edge detect and margin
  task automatic set_pin(input logic sel_b, input logic lvl);
    if (sel_b) begin
      pin_b_o <= lvl;
    end else begin
      pin_a_o <= lvl;
    end
    repeat (6) @(posedge clk_i);
  endtask : set_pin
endmodule : csc_periph_model

// file: csc_core_regs_test.sv
// self-checking testbench for the core system-control register bank
`timescale 1ns/100ps
module csc_core_regs_test;
  // {src, div_log2, rsvd} per selector code, first table then second
  localparam logic [7:0] EXP_SEL [16] = '{8'h04, 8'h02, 8'h31, 8'h24, 8'h22, 8'h20, 8'h14,
    8'h10, 8'h08, 8'h06, 8'h18, 8'h0a, 8'h0c, 8'h26, 8'h31, 8'h31};
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, alu_a = 8'h00, alu_b = 8'h00, lres = 8'h00;
  logic wr = 1'b0, rd = 1'b0, alu_v = 1'b0, alu_cin = 1'b0, shift_c = 1'b0;
  csc_pkg::csc_alu_op_type alu_op = csc_pkg::CSC_OP_ADD;
  csc_pkg::csc_clk_src_type src;
  logic [7:0] rdata, sp, evt;
  logic [3:0] flags;
  logic [2:0] div;
  logic rsvd, fast_en, slow_en, wdt_en, rst_sel, wake, irq, pin_a, pin_b;
  int miscompares = 0;
  int checks = 0;
  int wakes = 0;

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (wake === 1'b1) wakes++;

  csc_periph_model periph_u (.clk_i(clk_i), .evt_o(evt), .pin_a_o(pin_a), .pin_b_o(pin_b));

  csc_core_regs dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .alu_valid_i(alu_v), .alu_op_i(alu_op), .alu_a_i(alu_a), .alu_b_i(alu_b),
    .alu_cin_i(alu_cin), .alu_logic_res_i(lres), .alu_shift_c_i(shift_c),
    .arith_flags_o(flags), .stack_pointer_o(sp), .third_timer_evt_i(evt[7]),
    .second_timer_evt_i(evt[6]), .pwm_generator_zero_evt_i(evt[5]),
    .comparator_evt_i(evt[4]), .sixteen_bit_timer_evt_i(evt[2]),
    .port_a_edge_pin_i(pin_a), .port_b_edge_pin_i(pin_b), .sys_clk_src_o(src),
    .sys_clk_div_log2_o(div), .sys_clk_sel_rsvd_o(rsvd), .fast_internal_rc_osc_en_o(fast_en),
    .slow_internal_rc_osc_en_o(slow_en), .watchdog_en_o(wdt_en),
    .external_reset_input_sel_o(rst_sel), .port_a_wake_o(wake), .irq_o(irq));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
    @(posedge clk_i);
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 chk(rdata, exp);
    @(posedge clk_i);
  endtask : rd_reg

  task automatic alu(input csc_pkg::csc_alu_op_type op, input logic [7:0] a, input logic [7:0] b,
      input logic c, input logic [3:0] exp);
    alu_op <= op;
    alu_a <= a;
    alu_b <= b;
    lres <= a;
    alu_cin <= c;
    shift_c <= c;
    alu_v <= 1'b1;
    @(posedge clk_i);
    alu_v <= 1'b0;
    #1 chk({4'h0, flags}, {4'h0, exp});
    @(posedge clk_i);
  endtask : alu

  task automatic out_chk(input logic [7:0] exp);
    #1 chk({4'h0, fast_en, slow_en, wdt_en, rst_sel}, exp);
  endtask : out_chk

  initial begin
    #(5000 * 10);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    #1 chk({2'b00, src, div, rsvd}, 8'h10);
    out_chk(8'h0e);
    rd_reg(8'h00, 8'hf4);
    rd_reg(8'h03, 8'hf6);
    rd_reg(8'h04, 8'h00);
    rd_reg(8'h05, 8'h00);
    wr_reg(8'h00, 8'h0a);
    rd_reg(8'h00, 8'hfa);
    alu(csc_pkg::CSC_OP_ADD, 8'h7f, 8'h01, 1'b0, 4'hc);
    alu(csc_pkg::CSC_OP_ADD, 8'hff, 8'h01, 1'b0, 4'h7);
    alu(csc_pkg::CSC_OP_ADD, 8'h0f, 8'h00, 1'b1, 4'h4);
    alu(csc_pkg::CSC_OP_SUB, 8'h00, 8'h01, 1'b0, 4'h6);
    alu(csc_pkg::CSC_OP_SUB, 8'h80, 8'h01, 1'b0, 4'hc);
    alu(csc_pkg::CSC_OP_LOGIC, 8'h00, 8'h00, 1'b0, 4'hd);
    alu(csc_pkg::CSC_OP_SHIFT, 8'h00, 8'h00, 1'b1, 4'hf);
    alu(csc_pkg::CSC_OP_LOGIC, 8'h3c, 8'h00, 1'b0, 4'he);
    alu(csc_pkg::CSC_OP_SUB, 8'h05, 8'h05, 1'b0, 4'h1);
    alu(csc_pkg::CSC_OP_SUB, 8'h10, 8'h0f, 1'b1, 4'h5);
    // software keeps the stack pointer even
    wr_reg(8'h02, 8'ha6);
    rd_reg(8'h02, 8'ha6);
    chk(sp, 8'ha6);
    wr_reg(8'h01, 8'h55);
    rd_reg(8'h01, 8'h00);
    rd_reg(8'h07, 8'h00);
    for (int t = 0; t < 2; t++) begin
      for (int c = 0; c < 8; c++) begin
        wr_reg(8'h03, {c[2:0], 1'b1, t[0], 3'b110});
        #1 chk({2'b00, src, div, rsvd}, EXP_SEL[t * 8 + c]);
      end
    end
    wr_reg(8'h03, 8'he2);
    out_chk(8'h00);
    wr_reg(8'h03, 8'hf7);
    out_chk(8'h0f);
    rd_reg(8'h03, 8'hf7);
    wr_reg(8'h03, 8'hf5);
    out_chk(8'h0d);
    wr_reg(8'h04, 8'hff);
    rd_reg(8'h04, 8'hf7);
    wr_reg(8'h04, 8'h00);
    periph_u.pulse(8'h10);
    #1 chk({7'h00, irq}, 8'h00);
    rd_reg(8'h05, 8'h10);
    wr_reg(8'h04, 8'h10);
    #1 chk({7'h00, irq}, 8'h01);
    wr_reg(8'h07, 8'h10);
    #1 chk({7'h00, irq}, 8'h00);
    periph_u.pulse(8'hf4);
    rd_reg(8'h05, 8'hf4);
    wr_reg(8'h04, 8'h04);
    #1 chk({7'h00, irq}, 8'h01);
    wr_reg(8'h07, 8'h04);
    #1 chk({7'h00, irq}, 8'h00);
    wr_reg(8'h05, 8'h00);
    periph_u.set_pin(1'b0, 1'b1);
    rd_reg(8'h05, 8'h01);
    wr_reg(8'h07, 8'hff);
    periph_u.set_pin(1'b0, 1'b0);
    rd_reg(8'h05, 8'h01);
    wr_reg(8'h07, 8'hff);
    wr_reg(8'h08, 8'h09);
    periph_u.set_pin(1'b0, 1'b1);
    rd_reg(8'h05, 8'h01);
    wr_reg(8'h07, 8'hff);
    periph_u.set_pin(1'b0, 1'b0);
    periph_u.set_pin(1'b1, 1'b1);
    rd_reg(8'h05, 8'h00);
    periph_u.set_pin(1'b1, 1'b0);
    rd_reg(8'h05, 8'h02);
    wr_reg(8'h07, 8'hff);
    wr_reg(8'h08, 8'h0f);
    rd_reg(8'h08, 8'h0f);
    periph_u.set_pin(1'b0, 1'b1);
    periph_u.set_pin(1'b1, 1'b1);
    rd_reg(8'h05, 8'h00);
    wr_reg(8'h08, 8'h00);
    wr_reg(8'h09, 8'h00);
    rd_reg(8'h09, 8'h00);
    periph_u.set_pin(1'b0, 1'b0);
    rd_reg(8'h05, 8'h00);
    chk(wakes[7:0], 8'h05);
    tally_and_finish();
  end
endmodule : csc_core_regs_test
